// File: inc/wrc_pkg.sv
// watchdog and reset-cause package: register map, field positions, timing
// assumes a 40 MHz hclk and a free-running 128 kHz watchdog oscillator pin
package wrc_pkg;

	// register byte offsets on the 32-bit bus
	localparam logic [7:0] FLAGS_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS  = 8'h04;
	localparam logic [7:0] COUNT_OFS = 8'h08;
	localparam int         ADDR_W    = 8;

	// reset-cause register fields
	localparam int         PWRON_BIT = 0;
	localparam int         EXT_BIT   = 1;
	localparam int         BROWN_BIT = 2;
	localparam int         WDOG_BIT  = 3;
	localparam int         JTAG_BIT  = 4;
	localparam int         FLAGS_W   = 5;
	localparam logic [4:0] FLAGS_RST = 5'h01;

	// watchdog control register fields
	localparam int         PS_LO_HI  = 2;
	localparam int         RE_BIT    = 3;
	localparam int         CE_BIT    = 4;
	localparam int         PS3_BIT   = 5;
	localparam int         IE_BIT    = 6;
	localparam int         FLAG_BIT  = 7;
	localparam logic [3:0] PS_RST    = 4'h0;
	localparam logic [3:0] PS_MAX    = 4'h9;

	// timing
	localparam int         OSC_KHZ       = 128;
	localparam int         CLK_MHZ       = 40;
	localparam int         TOUT_MIN_MS   = 16;
	localparam int         TOUT_MAX_S    = 8;
	localparam int         BASE_CYCLES   = 2048;
	localparam int         CNT_W         = 21;
	localparam int         CE_WIN_CYCLES = 4;

	// ahb encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// File: rtl/wrc_top.sv
// watchdog timer with reset-cause flags, AHB-Lite register slave
// assumes: osc_pin is a free 128 kHz clock from its own oscillator, sampled
// here; restart_req and irq_ack are one-cycle pulses from the cpu on hclk;
// hresetn is the power-on reset, external, brown-out and jtag causes arrive as level pins.
//
// What this block does
// RULE1: counter advances on separate oscillator ticks
// RULE2: time-out gives interrupt or reset by mode
// RULE3: restart request clears counter; software restarts in time
// RULE4: interrupt mode raises wake-capable interrupt request
// RULE5: reset mode expiry issues system reset
// RULE6: combined mode interrupts first, then resets
// RULE7: fuse forces reset-enable one, interrupt-enable zero
// RULE8: software writes change-enable and reset-enable together
// RULE9: changes accepted only within four-cycle window; the code windows only prescaler and RE clear
// RULE10: prescaler selects 16 ms up to 8 s
// RULE11: software restarts before changing prescaler
// RULE12: watchdog stays enabled after watchdog reset
// RULE13: init code clears watchdog flag and reset-enable
// RULE14: jtag flag set by jtag reset, cleared
// RULE15: watchdog flag set by watchdog reset, cleared
// RULE16: brown-out flag set by brown-out, cleared
// RULE17: external flag set by pin reset, cleared
// RULE18: power-on flag cleared only by software
// RULE19: software reads then clears cause flags early
// RULE20: reset-enable stuck while watchdog flag set
// RULE21: change-enable self-clears after four cycles
// RULE22: combined-mode vectoring clears enable and flag
// RULE23: codes 0-9 give 2048 doubling cycles
// RULE24: out-of-window changes leave fields unchanged; the code still takes IE writes, flag clears and RE sets at any time
`timescale 1ns/10ps
module wrc_top
#(
	parameter int unsigned TIMEOUT_BASE = wrc_pkg::BASE_CYCLES
)
(
	// clock and power-on reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// oscillator, fuse and reset-cause pins
	input  wire logic        osc_pin,
	input  wire logic        always_on_fuse,
	input  wire logic        ext_reset_pin,
	input  wire logic        brownout_reset,
	input  wire logic        jtag_reset_instruction,
	// cpu side
	input  wire logic        restart_req,
	input  wire logic        irq_ack,
	output logic             irq,
	output logic             sys_reset
);
	import wrc_pkg::*;

	logic [4:0]        sync1_q;
	logic [4:0]        sync2_q;
	logic              osc_prev_q;
	logic              osc_tick;
	logic              fuse_s;
	logic              aphase;
	logic              dwr_q;
	logic [ADDR_W-1:0] daddr_q;
	logic              wr_ctrl;
	logic              wr_flags;
	logic [7:0]        wd;
	logic [FLAGS_W-1:0] flags_q;
	logic [FLAGS_W-1:0] flag_set;
	logic              ce_q;
	logic [2:0]        win_q;
	logic              re_q;
	logic              ie_q;
	logic              tflag_q;
	logic [3:0]        psel_q;
	logic              re_eff;
	logic              win_ok;
	logic              run;
	logic [CNT_W-1:0]  cnt_q;
	logic [CNT_W-1:0]  limit;
	logic              expire;
	logic              exp_rst;
	logic              exp_int;
	logic              comb_ack;
	logic [7:0]        ctrl_rd;
	logic              rd_hazard;
	logic              rd_load;
	logic              rd_wait_q;
	logic [ADDR_W-1:0] rd_addr;

	// two-flop synchronisers for every pin from outside the hclk domain
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end
		else
		begin
			sync1_q <= {jtag_reset_instruction, brownout_reset, ext_reset_pin,
				always_on_fuse, osc_pin};
			sync2_q <= sync1_q;
		end
	end

	// oscillator rising edge becomes a one-cycle tick enable
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			osc_prev_q <= 1'b0;
		else
			osc_prev_q <= sync2_q[0];
	end
	assign osc_tick = sync2_q[0] & ~osc_prev_q; // [RULE1]
	assign fuse_s   = sync2_q[1];

	// ahb address phase capture; held while the slave stretches a read
	assign aphase = hsel & hready & htrans[1];
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dwr_q   <= 1'b0;
			daddr_q <= '0;
		end
		else if (hready)
		begin
			dwr_q   <= aphase & hwrite & (hsize == HSIZE_WORD);
			daddr_q <= haddr[ADDR_W-1:0];
		end
	end
	assign wd       = hwdata[7:0];
	assign wr_ctrl  = dwr_q & (daddr_q == CTRL_OFS);
	assign wr_flags = dwr_q & (daddr_q == FLAGS_OFS);

	// bus answer flops: a read right behind a write gets one wait state, since
	// its data would otherwise be latched before the write has landed
	assign rd_hazard = aphase & ~hwrite & dwr_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			rd_wait_q <= 1'b0;
		end
		else
		begin
			hreadyout <= ~rd_hazard;
			hresp     <= 1'b0;
			rd_wait_q <= rd_hazard;
		end
	end

	// read data is latched at the address phase so it stands in the data phase;
	// a stalled read latches one cycle later from the held address
	always_comb
	begin
		ctrl_rd           = 8'h00;
		ctrl_rd[FLAG_BIT] = tflag_q;
		ctrl_rd[IE_BIT]   = ie_q;
		ctrl_rd[PS3_BIT]  = psel_q[3];
		ctrl_rd[CE_BIT]   = ce_q;
		ctrl_rd[RE_BIT]   = re_eff; // [RULE20]
		ctrl_rd[PS_LO_HI:0] = psel_q[2:0];
	end
	assign rd_load = (aphase & ~hwrite & ~dwr_q) | rd_wait_q;
	assign rd_addr = rd_wait_q ? daddr_q : haddr[ADDR_W-1:0];
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (rd_load)
		begin
			unique case (rd_addr)
				FLAGS_OFS: hrdata <= {27'h0000000, flags_q};
				CTRL_OFS:  hrdata <= {24'h000000, ctrl_rd};
				COUNT_OFS: hrdata <= {11'h000, cnt_q};
				default:   hrdata <= 32'h00000000;
			endcase
		end
	end

	// reset-cause flags: set beats a software clear in the same cycle;
	// power-on flag is set by hresetn itself and only software clears it
	assign flag_set[PWRON_BIT] = 1'b0;
	assign flag_set[EXT_BIT]   = sync2_q[2]; // [RULE17]
	assign flag_set[BROWN_BIT] = sync2_q[3]; // [RULE16]
	assign flag_set[WDOG_BIT]  = exp_rst;    // [RULE15]
	assign flag_set[JTAG_BIT]  = sync2_q[4]; // [RULE14]
	genvar gi;
	generate
		for (gi = 0; gi < FLAGS_W; gi++)
		begin : g_flag
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					flags_q[gi] <= FLAGS_RST[gi]; // [RULE18]
				else if (flag_set[gi])
					flags_q[gi] <= 1'b1;
				else if (wr_flags && !wd[gi])
					flags_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// watchdog flag and fuse override reset-enable
	assign re_eff = re_q | flags_q[WDOG_BIT] | fuse_s; // [RULE7] [RULE12] [RULE20]
	// a change write lands while the window is open with change-enable clear
	assign win_ok = wr_ctrl & ce_q & ~wd[CE_BIT]; // [RULE9] [RULE24]

	// change-enable window; a second unlock while open is ignored
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ce_q  <= 1'b0;
			win_q <= 3'h0;
		end
		else if (ce_q)
		begin
			win_q <= win_q - 3'h1;
			if (win_q == 3'h1)
				ce_q <= 1'b0; // [RULE21]
		end
		else if (wr_ctrl && wd[CE_BIT] && wd[RE_BIT])
		begin
			ce_q  <= 1'b1; // [RULE8]
			win_q <= 3'(CE_WIN_CYCLES);
		end
	end

	// reset-enable: set at any time, cleared only by a window write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			re_q <= 1'b0;
		else if (fuse_s)
			re_q <= 1'b1; // [RULE7]
		else if (wr_ctrl && wd[RE_BIT])
			re_q <= 1'b1;
		else if (win_ok && !flags_q[WDOG_BIT])
			re_q <= 1'b0; // [RULE9] [RULE20]
	end

	// prescaler only moves inside the window
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			psel_q <= PS_RST;
		else if (win_ok)
			psel_q <= {wd[PS3_BIT], wd[PS_LO_HI:0]}; // [RULE9] [RULE24]
	end

	// mode decode
	assign comb_ack = irq_ack & ie_q & re_eff;
	assign run      = re_eff | ie_q;
	// reserved codes clamp to the longest period rather than stop the dog
	assign limit    = (psel_q > PS_MAX) ? CNT_W'(TIMEOUT_BASE << PS_MAX)
		: CNT_W'(TIMEOUT_BASE << psel_q); // [RULE10] [RULE23]
	// >= so a shorter period picked mid-count expires on the next oscillator tick
	assign expire   = run & osc_tick & (cnt_q >= limit - CNT_W'(1)); // [RULE2]
	assign exp_rst  = expire & re_eff & (~ie_q | tflag_q); // [RULE5] [RULE6]
	assign exp_int  = expire & ie_q & ~exp_rst; // [RULE4] [RULE6]

	// interrupt-enable: vectoring in combined mode drops it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ie_q <= 1'b0;
		else if (fuse_s)
			ie_q <= 1'b0; // [RULE7]
		else if (comb_ack)
			ie_q <= 1'b0; // [RULE22]
		else if (wr_ctrl)
			ie_q <= wd[IE_BIT];
	end

	// time-out interrupt flag: expiry wins over ack and write-one clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tflag_q <= 1'b0;
		else if (exp_int)
			tflag_q <= 1'b1; // [RULE4] [RULE6]
		else if (irq_ack || (wr_ctrl && wd[FLAG_BIT]))
			tflag_q <= 1'b0; // [RULE22]
	end

	// counter: restart wins over a tick in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_q <= '0;
		else if (restart_req || !run || expire)
			cnt_q <= '0; // [RULE3]
		else if (osc_tick)
			cnt_q <= cnt_q + CNT_W'(1); // [RULE1]
	end

	// registered outputs; irq level also serves as sleep wake-up
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq       <= 1'b0;
			sys_reset <= 1'b0;
		end
		else
		begin
			irq       <= (tflag_q | exp_int) & ~comb_ack; // [RULE4]
			sys_reset <= exp_rst; // [RULE5]
		end
	end

	a_restart_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		restart_req |=> cnt_q == '0) // [RULE3]
		else $error("counter not cleared by restart");
	a_reset_only: assert property (@(posedge hclk) disable iff (!hresetn)
		expire && re_eff && !ie_q |=> sys_reset && flags_q[WDOG_BIT]) // [RULE5]
		else $error("reset mode expiry gave no reset");
	a_int_mode: assert property (@(posedge hclk) disable iff (!hresetn)
		expire && ie_q && !re_eff |=> tflag_q && !sys_reset ##1 irq) // [RULE4]
		else $error("interrupt mode expiry wrong");
	a_combined_first: assert property (@(posedge hclk) disable iff (!hresetn)
		expire && ie_q && re_eff && !tflag_q |=> tflag_q && !sys_reset) // [RULE6]
		else $error("combined mode first expiry wrong");
	a_fuse_locks: assert property (@(posedge hclk) disable iff (!hresetn)
		fuse_s && $past(fuse_s) |-> re_eff && !ie_q) // [RULE7]
		else $error("fuse did not lock mode bits");
	a_ce_window: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ce_q) |-> ce_q[*4] ##1 !ce_q) // [RULE21]
		else $error("change enable not four cycles");
	a_psel_locked: assert property (@(posedge hclk) disable iff (!hresetn)
		$changed(psel_q) |-> $past(ce_q)) // [RULE24]
		else $error("prescaler changed outside window");
	a_re_locked: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(re_q) |-> $past(ce_q) && !$past(flags_q[WDOG_BIT])) // [RULE9]
		else $error("reset enable cleared illegally");
	a_re_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		flags_q[WDOG_BIT] |-> re_eff) // [RULE20]
		else $error("reset enable low with watchdog flag");
	a_combined_ack: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_ack && ie_q && re_eff && !expire |=> !ie_q && !tflag_q) // [RULE22]
		else $error("combined ack did not clear");
	a_por_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(flags_q[PWRON_BIT]) |-> $past(wr_flags)) // [RULE18]
		else $error("power-on flag cleared by hardware");
	a_ext_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		sync2_q[2] |=> flags_q[EXT_BIT]) // [RULE17]
		else $error("external flag not set");

endmodule

// File: bench/wrc_top_tb.sv
// self-checking bench for the watchdog and reset-cause block
// assumes an AHB-Lite slave that may stretch via hreadyout; 128 kHz osc made here
`timescale 1ns/10ps
module wrc_top_tb;
	import wrc_pkg::*;
	localparam int TB = 4;
	// bench signals
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, osc_pin = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic        hreadyout, hresp, irq, sys_reset;
	logic        fuse = 0, ext_p = 0, bo_p = 0, jt_p = 0, rst_req = 0, ack = 0;
	logic [31:0] lfsr = 32'h900D;
	int          errors = 0, n_checks = 0, cyc = 0, n, mflags, mctrl;
	// clocks: oscillator free-running, unrelated to hclk
	always #12.5 hclk = ~hclk;
	always #3906 osc_pin = ~osc_pin;
	wrc_top #(.TIMEOUT_BASE(TB)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.osc_pin(osc_pin), .always_on_fuse(fuse), .ext_reset_pin(ext_p),
		.brownout_reset(bo_p), .jtag_reset_instruction(jt_p), .restart_req(rst_req),
		.irq_ack(ack), .irq(irq), .sys_reset(sys_reset));
	function automatic logic [31:0] lfsr_f(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one single word transfer; upper data bits random, ignored by the slave
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		lfsr = lfsr_f(lfsr);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {lfsr[31:8], d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(r, exp);
	endtask
	// pulse restart (0) or interrupt acknowledge (1) for one cycle
	task automatic pulse(input bit k);
		@(posedge hclk);
		if (k) ack <= 1'b1; else rst_req <= 1'b1;
		@(posedge hclk);
		ack <= 1'b0;
		rst_req <= 1'b0;
	endtask
	// bounded wait for irq (0) or system reset (1); n counts hclk cycles
	task automatic wait_out(input bit k, output int cnt);
		cnt = 0;
		do
		begin
			@(posedge hclk);
			#1;
			cnt++;
		end
		while (((k ? sys_reset : irq) !== 1'b1) && cnt < 4000);
		if (cnt >= 4000)
			chk(32'h0, 32'h1);
	endtask
	// hang guard: longest path is a few thousand cycles per expiry
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			errors++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		mflags = 32'h01;
		mctrl = 0;
		rd(FLAGS_OFS, mflags);
		rd(CTRL_OFS, mctrl);
		bus(1'b1, 8'h0C, 8'hFF);
		rd(8'h0C, 32'h0);
		// raise the external, brown-out and jtag reset causes together
		@(posedge hclk);
		{ext_p, bo_p, jt_p} <= 3'h7;
		repeat (6) @(posedge hclk);
		{ext_p, bo_p, jt_p} <= 3'h0;
		repeat (4) @(posedge hclk);
		mflags = mflags | 32'h16;
		rd(FLAGS_OFS, mflags);
		bus(1'b1, FLAGS_OFS, 8'h00);
		bus(1'b1, FLAGS_OFS, 8'hFF);
		mflags = 0;
		rd(FLAGS_OFS, mflags);
		// interrupt mode, period of TB ticks of about 312 hclk each
		bus(1'b1, CTRL_OFS, 8'h40);
		pulse(1'b0);
		wait_out(1'b0, n);
		chk(n > (TB - 1) * 300 && n < (TB + 1) * 320, 1);
		rd(CTRL_OFS, 32'hC0);
		pulse(1'b1);
		rd(CTRL_OFS, 32'h40);
		// restarts at random spacing well inside the period hold off expiry
		pulse(1'b0);
		repeat (12)
		begin
			lfsr = lfsr_f(lfsr);
			repeat (50 + lfsr[7:0] % 200) @(posedge hclk);
			pulse(1'b0);
			chk(irq, 1'b0);
		end
		// combined mode: interrupt first, reset on the next expiry
		bus(1'b1, CTRL_OFS, 8'h48);
		pulse(1'b0);
		wait_out(1'b0, n);
		chk(sys_reset, 1'b0);
		pulse(1'b1);
		mctrl = 32'h08;
		rd(CTRL_OFS, mctrl);
		wait_out(1'b1, n);
		chk(n < (TB + 1) * 320, 1);
		mflags = 32'h08;
		rd(FLAGS_OFS, mflags);
		// reset-enable cannot drop while the watchdog flag is set
		bus(1'b1, CTRL_OFS, 8'h18);
		bus(1'b1, CTRL_OFS, 8'h00);
		rd(CTRL_OFS, mctrl);
		bus(1'b1, FLAGS_OFS, 8'h00);
		pulse(1'b0);
		bus(1'b1, CTRL_OFS, 8'h18);
		bus(1'b1, CTRL_OFS, 8'h00);
		mctrl = 0;
		rd(CTRL_OFS, mctrl);
		rd(COUNT_OFS, 32'h0);
		// prescaler write with no window open is ignored
		bus(1'b1, CTRL_OFS, 8'h07);
		rd(CTRL_OFS, mctrl);
		// window expires four cycles after unlock
		bus(1'b1, CTRL_OFS, 8'h18);
		repeat (6) @(posedge hclk);
		bus(1'b1, CTRL_OFS, 8'h01);
		rd(CTRL_OFS, 32'h08);
		// restart, then code 1 in a window: interrupt mode, period doubled
		pulse(1'b0);
		bus(1'b1, CTRL_OFS, 8'h18);
		bus(1'b1, CTRL_OFS, 8'h41);
		pulse(1'b0);
		wait_out(1'b0, n);
		chk(n > (2 * TB - 1) * 300 && n < (2 * TB + 1) * 320, 1);
		rd(CTRL_OFS, 32'hC1);
		pulse(1'b1);
		// fuse forces reset-only mode
		@(posedge hclk);
		fuse <= 1'b1;
		pulse(1'b0);
		bus(1'b1, CTRL_OFS, 8'h40);
		repeat (4) @(posedge hclk);
		rd(CTRL_OFS, 32'h09);
		wait_out(1'b1, n);
		chk(n < (2 * TB + 1) * 320, 1);
		chk(irq, 1'b0);
		report_and_stop();
	end
endmodule
